// >>> logic/pmx_pkg.sv
package pmx_pkg;

    // -----------------------------------------------------------------
    // register map and field positions
    // -----------------------------------------------------------------
    localparam int          ADDR_W       = 5;
    localparam int          REG_W        = 16;
    localparam [4:0]        OFS_BASIC    = 5'h00;
    localparam [4:0]        OFS_IRQ      = 5'h1b;
    localparam [4:0]        OFS_CTRL2    = 5'h1f;
    localparam int          BIT_DUPLEX   = 8;
    localparam int          BIT_DISCONNECT_SETTING  = 10;
    localparam int          BIT_IRQ_POL  = 9;
    localparam int          IRQ_W        = 8;
    localparam int          IRQ_EN_LSB   = 8;
    localparam [15:0]       REG_ZERO     = 16'h0000;

    // -----------------------------------------------------------------
    // clock rates and derived divisors
    // -----------------------------------------------------------------
    localparam int          SYS_MHZ      = 125;
    localparam int          MII_MHZ      = 25;
    localparam int          RMII_MHZ     = 50;
    localparam int          SMII_MHZ     = 125;
    localparam [2:0]        DIV_MII      = 3'(SYS_MHZ / MII_MHZ);
    localparam [2:0]        DIV_RMII     = 3'(SYS_MHZ / RMII_MHZ);
    localparam [2:0]        DIV_SMII     = 3'(SYS_MHZ / SMII_MHZ);

    // -----------------------------------------------------------------
    // strap window, slices, synchroniser bit positions
    // -----------------------------------------------------------------
    localparam [1:0]        STRAP_LAST   = 2'h2;
    localparam [2:0]        SL_MII       = 3'h1;
    localparam [2:0]        SL_RMII      = 3'h2;
    localparam [2:0]        SL_SMII      = 3'h6;
    localparam [2:0]        SMII_TX_LAST = 3'h4;
    localparam int          SYNC_W       = 10;
    localparam int          P_RXD0       = 0;
    localparam int          P_RXD1       = 1;
    localparam int          P_RXV        = 2;
    localparam int          P_RXE        = 3;
    localparam int          P_TX_ENABLE_IN       = 4;
    localparam int          P_TXD        = 5;
    localparam int          P_TXC        = 9;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {PMX_MII, PMX_RMII, PMX_SMII, PMX_MII_B2B} pmx_mode_t;
    typedef enum logic {PMX_STRAP, PMX_RUN} pmx_phase_t;

    typedef struct packed {
        logic       err;
        logic [3:0] data;
    } pmx_rx_word_t;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } pmx_tx_word_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } pmx_reg_req_t;

endpackage

// >>> logic/pmx_pin_mux.sv
`timescale 1ns/10ps
module pmx_pin_mux
    import pmx_pkg::*;
(
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    input  wire pmx_mode_t    mode_sel_in,
    input  wire logic [3:0]   rxd_pin_in,
    input  wire logic         rx_valid_pin_in,
    input  wire logic         rx_error_pin_in,
    input  wire logic         tx_clock_pin_in,
    input  wire logic         tx_enable_in,
    input  wire logic [3:0]   txd_pin_in,
    input  wire logic         core_rx_valid_in,
    input  wire pmx_rx_word_t core_rx_in,
    input  wire logic [7:0]   event_in,
    input  wire pmx_reg_req_t reg_req_in,
    output logic [3:0]        rxd_pin_out,
    output logic              rx_valid_out,
    output logic              rx_error_out,
    output logic              rx_pins_oe_out,
    output logic              rx_clock_out,
    output logic              tx_clock_pin_out,
    output logic              tx_clock_pin_oe_out,
    output logic              core_rx_ready_out,
    output pmx_tx_word_t      core_tx_out,
    output logic              core_tx_stb_out,
    output logic [15:0]       reg_rdata_out,
    output logic              irq_out,
    output logic              station_addr_bit2_strap_out,
    output logic              iface_mode_strap_bit2_out
);

    // -----------------------------------------------------------------
    // state of the block
    // -----------------------------------------------------------------
    typedef struct packed {
        pmx_phase_t              phase;
        logic [1:0]              strap_cnt;
        logic [SYNC_W-1:0]       sync1;
        logic [SYNC_W-1:0]       sync2;
        logic                    txc_prev;
        logic                    sync_prev;
        logic                    addr2;
        logic                    cfg2;
        logic [15:0]             ctrl0;
        logic [IRQ_W-1:0]        irq_st;
        logic [IRQ_W-1:0]        irq_en;
        logic [15:0]             ctrl2;
        logic [15:0]             rdata;
        logic                    irq;
        logic [2:0]              div_cnt;
        logic                    clk_lvl;
        pmx_rx_word_t [1:0]      fifo;
        logic                    wp;
        logic                    rp;
        logic [1:0]              cnt;
        logic                    rdy;
        pmx_rx_word_t            ser_w;
        logic                    ser_busy;
        logic [2:0]              ser_idx;
        logic [3:0]              rxd;
        logic                    rxv;
        logic                    rxe;
        logic                    oe;
        logic                    txc_oe;
        logic [3:0]              tx_sh;
        logic [2:0]              tx_idx;
        pmx_tx_word_t            tx_w;
        logic                    tx_stb;
    } pmx_state_t;

    pmx_state_t st_r;
    pmx_state_t st_nxt;

    // clock divisor and slice count per mode
    function automatic logic [2:0] div_of(input pmx_mode_t m);
        case (m)
            PMX_RMII: div_of = DIV_RMII;
            PMX_SMII: div_of = DIV_SMII;
            default:  div_of = DIV_MII;
        endcase
    endfunction

    function automatic logic [2:0] slices_of(input pmx_mode_t m);
        case (m)
            PMX_RMII: slices_of = SL_RMII;
            PMX_SMII: slices_of = SL_SMII;
            default:  slices_of = SL_MII;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb
    begin
        logic         tick;
        logic         pop;
        logic         push;
        logic         busy;
        logic         act;
        logic         sync_rise;
        pmx_rx_word_t w;
        logic [2:0]   i;
        st_nxt    = st_r;
        tick      = 1'b0;
        pop       = 1'b0;
        push      = 1'b0;
        busy      = 1'b0;
        act       = 1'b0;
        sync_rise = 1'b0;
        w         = '0;
        i         = 3'h0;
        // pins pass two flops before anything reads them
        st_nxt.sync1 = {tx_clock_pin_in, txd_pin_in, tx_enable_in,
                        rx_error_pin_in, rx_valid_pin_in, rxd_pin_in[1:0]};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.txc_prev  = st_r.sync2[P_TXC];
        st_nxt.sync_prev = st_r.sync2[P_TXD+1];

        // strap window: outputs stay off until the synchroniser has settled
        if (st_r.phase == PMX_STRAP)
        begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            if (st_r.strap_cnt == STRAP_LAST)
            begin
                st_nxt.addr2               = st_r.sync2[P_RXD1];
                st_nxt.ctrl0[BIT_DUPLEX]   = st_r.sync2[P_RXD0];
                st_nxt.cfg2                = st_r.sync2[P_RXV];
                st_nxt.ctrl0[BIT_DISCONNECT_SETTING]  = st_r.sync2[P_RXE];
                st_nxt.phase               = PMX_RUN;
            end
        end

        // register port; status read clears, a new event wins over the clear
        st_nxt.irq_st = st_r.irq_st | event_in;
        if (reg_req_in.rd)
        begin
            case (reg_req_in.addr)
                OFS_BASIC: st_nxt.rdata = st_r.ctrl0;
                OFS_IRQ:
                begin
                    st_nxt.rdata  = {st_r.irq_en, st_r.irq_st};
                    st_nxt.irq_st = event_in;
                end
                OFS_CTRL2: st_nxt.rdata = st_r.ctrl2;
                default:   st_nxt.rdata = REG_ZERO;
            endcase
        end
        if (reg_req_in.wr && st_r.phase == PMX_RUN)
        begin
            case (reg_req_in.addr)
                OFS_BASIC: st_nxt.ctrl0  = reg_req_in.wdata;
                OFS_IRQ:   st_nxt.irq_en = reg_req_in.wdata[IRQ_EN_LSB +: IRQ_W];
                OFS_CTRL2: st_nxt.ctrl2  = reg_req_in.wdata;
                default:   ;
            endcase
        end
        act        = |(st_r.irq_st & st_r.irq_en);
        st_nxt.irq = st_r.ctrl2[BIT_IRQ_POL] ? act : ~act;

        // link clock: own divider, or the mac's clock in back-to-back mode
        if (mode_sel_in == PMX_MII_B2B)
        begin
            tick           = st_r.sync2[P_TXC] & ~st_r.txc_prev;
            st_nxt.div_cnt = 3'h0;
            st_nxt.clk_lvl = st_r.sync2[P_TXC];
        end
        else
        begin
            tick           = (st_r.div_cnt >= div_of(mode_sel_in) - 3'h1);
            st_nxt.div_cnt = tick ? 3'h0 : st_r.div_cnt + 3'h1;
            // at the system rate the clock pin cannot toggle, so it rests low
            st_nxt.clk_lvl = (st_nxt.div_cnt < (div_of(mode_sel_in) >> 1));
        end
        st_nxt.txc_oe = (st_r.phase == PMX_RUN) && (mode_sel_in != PMX_MII_B2B);
        st_nxt.oe     = (st_r.phase == PMX_RUN) && !st_r.ctrl0[BIT_DISCONNECT_SETTING];

        // receive serializer: a word is taken from the buffer at slice 0
        if (st_r.ser_idx == 3'h0)
        begin
            busy = (st_r.cnt != 2'h0);
            w    = busy ? st_r.fifo[st_r.rp] : '0;
        end
        else
        begin
            busy = st_r.ser_busy;
            w    = st_r.ser_w;
        end
        if (tick && st_r.phase == PMX_RUN)
        begin
            pop             = (st_r.ser_idx == 3'h0) && busy;
            st_nxt.ser_w    = w;
            st_nxt.ser_busy = busy;
            st_nxt.ser_idx  = (st_r.ser_idx + 3'h1 >= slices_of(mode_sel_in))
                              ? 3'h0 : st_r.ser_idx + 3'h1;
            case (mode_sel_in)
                PMX_RMII:
                begin
                    st_nxt.rxd = {2'b00, st_r.ser_idx[0] ? w.data[3:2] : w.data[1:0]};
                    st_nxt.rxv = busy;
                    st_nxt.rxe = busy & w.err;
                end
                PMX_SMII:
                begin
                    i = st_r.ser_idx - 3'h2;
                    st_nxt.rxv = 1'b0;
                    st_nxt.rxe = 1'b0;
                    case (st_r.ser_idx)
                        3'h0:    st_nxt.rxd = {3'b000, busy};
                        3'h1:    st_nxt.rxd = {3'b000, busy & w.err};
                        default: st_nxt.rxd = {3'b000, w.data[i[1:0]]};
                    endcase
                end
                default:
                begin
                    st_nxt.rxd = w.data;
                    st_nxt.rxv = busy;
                    st_nxt.rxe = busy & w.err;
                end
            endcase
        end

        // two-entry buffer; ready is registered, so it reflects next count
        push = core_rx_valid_in && st_r.rdy;
        if (push)
        begin
            st_nxt.fifo[st_r.wp] = core_rx_in;
            st_nxt.wp            = ~st_r.wp;
        end
        if (pop)
            st_nxt.rp = ~st_r.rp;
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
        st_nxt.rdy = (st_nxt.cnt != 2'h2);

        // transmit capture on the link clock edge
        st_nxt.tx_stb = 1'b0;
        sync_rise     = st_r.sync2[P_TXD+1] & ~st_r.sync_prev;
        if (tick && st_r.phase == PMX_RUN)
        begin
            case (mode_sel_in)
                PMX_RMII:
                begin
                    if (!st_r.sync2[P_TX_ENABLE_IN] || st_r.tx_idx != 3'h0)
                    begin
                        st_nxt.tx_idx = 3'h0;
                        st_nxt.tx_w   = {st_r.sync2[P_TX_ENABLE_IN],
                                         st_r.sync2[P_TXD +: 2], st_r.tx_sh[1:0]};
                        st_nxt.tx_stb = st_r.tx_idx != 3'h0;
                    end
                    else
                    begin
                        st_nxt.tx_sh  = {2'b00, st_r.sync2[P_TXD +: 2]};
                        st_nxt.tx_idx = 3'h1;
                    end
                end
                PMX_SMII:
                begin
                    if (sync_rise)
                    begin
                        st_nxt.tx_w.en = st_r.sync2[P_TXD];
                        st_nxt.tx_idx  = 3'h1;
                    end
                    else if (st_r.tx_idx != 3'h0)
                    begin
                        st_nxt.tx_sh  = {st_r.sync2[P_TXD], st_r.tx_sh[3:1]};
                        st_nxt.tx_idx = (st_r.tx_idx == SMII_TX_LAST) ? 3'h0
                                        : st_r.tx_idx + 3'h1;
                        if (st_r.tx_idx == SMII_TX_LAST)
                        begin
                            st_nxt.tx_w.data = {st_r.sync2[P_TXD], st_r.tx_sh[3:1]};
                            st_nxt.tx_stb    = 1'b1;
                        end
                    end
                end
                default:
                begin
                    st_nxt.tx_w   = {st_r.sync2[P_TX_ENABLE_IN], st_r.sync2[P_TXD +: 4]};
                    st_nxt.tx_stb = 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r       <= '0;
            st_r.irq   <= 1'b1;  // inactive level of the default low polarity
            st_r.phase <= PMX_STRAP;
        end
        else
            st_r <= st_nxt;
    end

    // outputs straight from the state register
    assign rxd_pin_out                 = st_r.rxd;
    assign rx_valid_out                = st_r.rxv;
    assign rx_error_out                = st_r.rxe;
    assign rx_pins_oe_out              = st_r.oe;
    assign rx_clock_out                = st_r.clk_lvl;
    assign tx_clock_pin_out            = st_r.clk_lvl;
    assign tx_clock_pin_oe_out         = st_r.txc_oe;
    assign core_rx_ready_out           = st_r.rdy;
    assign core_tx_out                 = st_r.tx_w;
    assign core_tx_stb_out             = st_r.tx_stb;
    assign reg_rdata_out               = st_r.rdata;
    assign irq_out                     = st_r.irq;
    assign station_addr_bit2_strap_out = st_r.addr2;
    assign iface_mode_strap_bit2_out   = st_r.cfg2;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_strap_addr_bit: assert property ($rose(st_r.phase == PMX_RUN) |->
        st_r.addr2 == $past(st_r.sync2[P_RXD1])) else $error("addr strap lost");
    a_strap_duplex: assert property ($rose(st_r.phase == PMX_RUN) |->
        st_r.ctrl0[BIT_DUPLEX] == $past(st_r.sync2[P_RXD0])) else $error("duplex strap lost");
    a_strap_cfg_bit: assert property ($rose(st_r.phase == PMX_RUN) |->
        st_r.cfg2 == $past(st_r.sync2[P_RXV])) else $error("mode strap lost");
    a_strap_disconnect_setting: assert property ($rose(st_r.phase == PMX_RUN) |->
        ##1 (rx_pins_oe_out == !st_r.ctrl0[BIT_DISCONNECT_SETTING] || $changed(st_r.ctrl0)))
        else $error("disconnect_setting strap not applied");
    a_irq_read_clear: assert property ((reg_req_in.rd && reg_req_in.addr == OFS_IRQ) |=>
        st_r.irq_st == $past(event_in) && reg_rdata_out[7:0] == $past(st_r.irq_st))
        else $error("status read/clear wrong");
    a_irq_polarity: assert property (##1 irq_out == ($past(st_r.ctrl2[BIT_IRQ_POL])
        ? |$past(st_r.irq_st & st_r.irq_en) : ~|$past(st_r.irq_st & st_r.irq_en)))
        else $error("irq polarity wrong");
    a_txc_direction: assert property ((st_r.phase == PMX_RUN) |=>
        tx_clock_pin_oe_out == ($past(mode_sel_in) != PMX_MII_B2B))
        else $error("tx clock direction wrong");
    a_rmii_upper_zero: assert property ((mode_sel_in == PMX_RMII) [*2] |->
        rxd_pin_out[3:2] == 2'b00 || $past(mode_sel_in, 2) != PMX_RMII)
        else $error("rmii upper bits driven");
    a_smii_serial_pin: assert property ((mode_sel_in == PMX_SMII) [*3] |->
        rxd_pin_out[3:1] == 3'b000 && !rx_valid_out)
        else $error("smii uses more than rxd0");
    a_strap_outputs_off: assert property ((st_r.phase == PMX_STRAP) |->
        !rx_pins_oe_out && !tx_clock_pin_oe_out) else $error("pins driven during straps");
    a_buffer_ready: assert property ((st_r.cnt == 2'h2) |-> !core_rx_ready_out)
        else $error("buffer overfill");

endmodule

// >>> verif/pmx_mac_model.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// far-side mac: strap resistors, transmit pins, back-to-back clock
// -----------------------------------------------------------------
module pmx_mac_model
    import pmx_pkg::*;
(
    input  wire logic [3:0]   strap_pull_in,
    input  wire pmx_tx_word_t tx_word_in,
    input  wire logic [3:0]   dev_rxd_in,
    input  wire logic         dev_rx_valid_in,
    input  wire logic         dev_rx_error_in,
    input  wire logic         dev_rx_oe_in,
    input  wire logic         dev_txc_in,
    input  wire logic         dev_txc_oe_in,
    output logic [3:0]        rxd_pin_out,
    output logic              rx_valid_pin_out,
    output logic              rx_error_pin_out,
    output logic              tx_clock_pin_out,
    output logic              tx_enable_out,
    output logic [3:0]        txd_pin_out
);
    logic link_clk_r;

    // free-running 125 ns transmit clock, phase unrelated to the system clock
    initial link_clk_r = 1'b0;
    always #62.5 link_clk_r = ~link_clk_r;

    // strap resistors win only while the device leaves the pins undriven
    assign rxd_pin_out      = dev_rx_oe_in ? dev_rxd_in : {2'b10, strap_pull_in[1:0]};
    assign rx_valid_pin_out = dev_rx_oe_in ? dev_rx_valid_in : strap_pull_in[2];
    assign rx_error_pin_out = dev_rx_oe_in ? dev_rx_error_in : strap_pull_in[3];

    // the mac clock shows on the pin whenever the device is not driving it
    assign tx_clock_pin_out = dev_txc_oe_in ? dev_txc_in : link_clk_r;
    // enable and nibble are held for a whole word, so any tick sees them
    assign tx_enable_out    = tx_word_in.en;
    assign txd_pin_out      = tx_word_in.data;
endmodule

// >>> verif/mac_side_pin_mux_and_straps_tb_top.sv
`timescale 1ns/10ps
module mac_side_pin_mux_and_straps_tb_top
    import pmx_pkg::*;
;
    logic         clk_sys_in, nrst_in, rx_valid_pin, rx_error_pin, tx_clock_pin, tx_enable;
    logic         core_rx_valid, rx_valid, rx_error, rx_oe, rx_clock, txc_out, txc_oe;
    logic         core_rx_ready, core_tx_stb, irq, strap_addr, strap_mode, rclk_d, half;
    logic         saw_full;
    logic [1:0]   lo;
    logic [3:0]   rxd_pin, txd_pin, rxd_out, pulls;
    logic [7:0]   event_v, en, ev;
    logic [15:0]  rdata, v;
    pmx_mode_t    mode_sel;
    pmx_rx_word_t core_rx;
    pmx_rx_word_t exp_q[$];
    pmx_tx_word_t core_tx, tx_word;
    pmx_reg_req_t reg_req;
    int           seed, miscompares, compares;

    // -----------------------------------------------------------------
    // design, far side and clock
    // -----------------------------------------------------------------
    pmx_pin_mux u_dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .mode_sel_in(mode_sel),
        .rxd_pin_in(rxd_pin), .rx_valid_pin_in(rx_valid_pin), .rx_error_pin_in(rx_error_pin),
        .tx_clock_pin_in(tx_clock_pin), .tx_enable_in(tx_enable), .txd_pin_in(txd_pin),
        .core_rx_valid_in(core_rx_valid), .core_rx_in(core_rx), .event_in(event_v),
        .reg_req_in(reg_req), .rxd_pin_out(rxd_out), .rx_valid_out(rx_valid),
        .rx_error_out(rx_error), .rx_pins_oe_out(rx_oe), .rx_clock_out(rx_clock),
        .tx_clock_pin_out(txc_out), .tx_clock_pin_oe_out(txc_oe),
        .core_rx_ready_out(core_rx_ready), .core_tx_out(core_tx), .core_tx_stb_out(core_tx_stb),
        .reg_rdata_out(rdata), .irq_out(irq), .station_addr_bit2_strap_out(strap_addr),
        .iface_mode_strap_bit2_out(strap_mode));

    pmx_mac_model u_mac (
        .strap_pull_in(pulls), .tx_word_in(tx_word), .dev_rxd_in(rxd_out),
        .dev_rx_valid_in(rx_valid), .dev_rx_error_in(rx_error), .dev_rx_oe_in(rx_oe),
        .dev_txc_in(txc_out), .dev_txc_oe_in(txc_oe), .rxd_pin_out(rxd_pin),
        .rx_valid_pin_out(rx_valid_pin), .rx_error_pin_out(rx_error_pin),
        .tx_clock_pin_out(tx_clock_pin), .tx_enable_out(tx_enable), .txd_pin_out(txd_pin));

    initial clk_sys_in = 1'b0;
    always #4 clk_sys_in = ~clk_sys_in;

    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    // one strobe cycle, then one idle cycle so read data has landed
    task automatic reg_acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
        reg_req = '{wr, ~wr, a, d};
        cyc(1);
        reg_req = '0;
        cyc(1);
    endtask

    // random strap levels held through reset; pins must stay undriven after release
    task automatic do_reset(input pmx_mode_t m);
        nrst_in = 1'b0;
        mode_sel = m;
        pulls = 4'($random(seed));
        cyc(16);
        nrst_in = 1'b1;
        cyc(1);
        check(16'(rx_oe), 0);
        cyc(8);
    endtask

    task automatic check_straps();
        check(16'(strap_addr), 16'(pulls[1]));
        check(16'(strap_mode), 16'(pulls[2]));
        reg_acc(1'b0, OFS_BASIC, 0);
        check(16'(rdata[BIT_DUPLEX]), 16'(pulls[0]));
        check(16'(rdata[BIT_DISCONNECT_SETTING]), 16'(pulls[3]));
    endtask

    task automatic take(input pmx_rx_word_t w);
        check(16'(w), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hffff);
    endtask

    // back-to-back words fill the buffer faster than the pins drain it
    task automatic stream();
        saw_full = 1'b0;
        core_rx_valid = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            core_rx = pmx_rx_word_t'(5'($random(seed)));
            for (int k = 0; k < 100 && !core_rx_ready; k++)
            begin
                saw_full = 1'b1;
                cyc(1);
            end
            exp_q.push_back(core_rx);
            cyc(1);
        end
        core_rx_valid = 1'b0;
        for (int i = 0; i < 300 && exp_q.size() > 0; i++)
            cyc(1);
        check(16'(exp_q.size()), 0);
        check(16'(saw_full), 1);
        exp_q.delete();
    endtask

    // serial frame on rxd0: valid, err, d0..d3, one bit a cycle
    task automatic smii_word();
        pmx_rx_word_t w;
        logic [4:0]   got;
        w = pmx_rx_word_t'(5'($random(seed)));
        core_rx_valid = 1'b1;
        core_rx = w;
        cyc(1);
        core_rx_valid = 1'b0;
        for (int i = 0; i < 40 && rxd_out[0] !== 1'b1; i++)
            cyc(1);
        for (int i = 0; i < 5; i++)
        begin
            cyc(1);
            got[i] = rxd_out[0];
        end
        check({11'h0, got}, {11'h0, w.data, w.err});
        check(16'({rx_valid, rx_error}), 0);
    endtask

    // mii and b2b take the nibble whole, rmii the held dibit twice, smii a framed serial word
    task automatic tx_check(input int m);
        pmx_tx_word_t w;
        w = pmx_tx_word_t'(5'($random(seed)));
        w.en = 1'b1;
        if (m == 2)
        begin
            // sync high for one cycle marks the enable bit, then d0..d3 lsb first
            tx_word = '{1'b0, {3'b001, w.en}};
            for (int i = 0; i < 4; i++)
            begin
                cyc(1);
                tx_word = '{1'b0, {3'b000, w.data[i]}};
            end
            cyc(1);
            tx_word = '0;
        end
        else
        begin
            tx_word = w;
            cyc(40);
        end
        // a held dibit is seen in both slices, so rmii pairs it with itself
        if (m == 1)
            w.data[3:2] = w.data[1:0];
        for (int i = 0; i < 60 && core_tx_stb !== 1'b1; i++)
            cyc(1);
        check(16'({core_tx_stb, core_tx}), 16'({1'b1, w}));
        tx_word = '0;
    endtask

    // both polarities; status bits written through 1Bh must not stick
    task automatic irq_check();
        for (int i = 0; i < 4; i++)
        begin
            v = 16'($random(seed));
            v[BIT_IRQ_POL] = i[0];
            en = 8'($random(seed)) | 8'h01;
            ev = 8'($random(seed)) | 8'h01;
            reg_acc(1'b1, OFS_CTRL2, v);
            reg_acc(1'b1, OFS_IRQ, {en, 8'hff});
            reg_acc(1'b0, OFS_CTRL2, 0);
            check(rdata, v);
            check(16'(irq), 16'(!i[0]));
            event_v = ev;
            cyc(1);
            event_v = 8'h00;
            cyc(3);
            check(16'(irq), 16'(i[0]));
            reg_acc(1'b0, OFS_IRQ, 0);
            check(rdata, {en, ev});
            cyc(2);
            reg_acc(1'b0, OFS_IRQ, 0);
            check(rdata, {en, 8'h00});
            check(16'(irq), 16'(!i[0]));
        end
    endtask

    // -----------------------------------------------------------------
    // receive monitor and main sequence
    // -----------------------------------------------------------------
    always @(negedge clk_sys_in)
    begin
        if (rx_clock && !rclk_d && rx_valid && mode_sel inside {PMX_MII, PMX_RMII})
        begin
            if (mode_sel == PMX_MII)
                take({rx_error, rxd_out});
            else if (half)
                take({rx_error, rxd_out[1:0], lo});
            else
                lo = rxd_out[1:0];
            half = (mode_sel == PMX_RMII) && !half;
        end
        else if (!rx_valid)
            half = 1'b0;
        rclk_d = rx_clock;
    end

    initial
    begin
        seed = 32282;
        miscompares = 0;
        compares = 0;
        half = 1'b0;
        reg_req = '0;
        event_v = 8'h00;
        core_rx_valid = 1'b0;
        core_rx = '0;
        tx_word = '0;
        for (int m = 0; m < 4; m++)
        begin
            do_reset(pmx_mode_t'(m));
            check(16'(irq), 1);
            check_straps();
            check(16'(txc_oe), 16'(m != 3));
            check(16'(rx_oe), 16'(!pulls[3]));
            if (m < 2)
                stream();
            if (m == 2)
                smii_word();
            tx_check(m);
            check_straps();
        end
        irq_check();
        v = 16'($random(seed));
        reg_acc(1'b1, OFS_BASIC, v);
        reg_acc(1'b0, OFS_BASIC, 0);
        check(rdata, v);
        reg_acc(1'b1, 5'h05, 16'hffff);
        reg_acc(1'b0, 5'h05, 0);
        check(rdata, 0);
        conclude();
    end

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        #(20000 * 8);
        miscompares++;
        conclude();
    end
endmodule
